// *** common/cco_defs.vh ***
// constants for the compare-output and event stage of one counter channel
// assumes a 100 MHz system clock; included by bare name from hdl files
`ifndef CCO_DEFS_VH
`define CCO_DEFS_VH

// register indices on the plain register port (4-bit address)
`define CCO_ADDR_W 4
`define CCO_REG_CTRL 4'h0
`define CCO_REG_CMPVAL 4'h1
`define CCO_REG_PULSE 4'h2
`define CCO_REG_HYST 4'h3
`define CCO_REG_FILT 4'h4
`define CCO_REG_COUNT 4'h5
`define CCO_REG_STATUS 4'h6
`define CCO_REG_EVENT 4'h7

// control register fields
`define CCO_CTRL_CHAR_LO 0
`define CCO_CTRL_CHAR_HI 1
`define CCO_CTRL_DIR_LO 2
`define CCO_CTRL_DIR_HI 3
`define CCO_CTRL_DOUT 4
`define CCO_CTRL_IE_GOPEN 8
`define CCO_CTRL_IE_GCLOSE 9
`define CCO_CTRL_IE_CMP 10
`define CCO_CTRL_IE_OFLW 11
`define CCO_CTRL_IE_UFLW 12
`define CCO_CTRL_RST 32'h0000_0000

// output characteristic encodings
`define CCO_CHAR_NONE 2'h0
`define CCO_CHAR_GE 2'h1
`define CCO_CHAR_LE 2'h2
`define CCO_CHAR_PULSE 2'h3

// main counting direction encodings
`define CCO_DIR_NONE 2'h0
`define CCO_DIR_UP 2'h1
`define CCO_DIR_DOWN 2'h2

// pulse length: 8-bit code, step 2 ms, max code 255 = 510 ms
`define CCO_PULSE_W 8
`define CCO_PULSE_STEP_MS 2
`define CCO_CLK_MHZ 100
// one millisecond tick, below 1 ms error
`define CCO_MS_CYCLES (`CCO_CLK_MHZ * 1000)
`define CCO_MS_W 17
`define CCO_PLEN_W 10

// filter frequency selection codes and minimum widths in ns
`define CCO_FSEL_W 3
`define CCO_F1K 3'h0
`define CCO_F2K 3'h1
`define CCO_F5K 3'h2
`define CCO_F10K 3'h3
`define CCO_F30K 3'h4
`define CCO_F60K 3'h5
`define CCO_W1K_NS 400000
`define CCO_W2K_NS 200000
`define CCO_W5K_NS 80000
`define CCO_W10K_NS 40000
`define CCO_W30K_NS 13000
`define CCO_W60K_NS 6700
`define CCO_CLK_NS 10
`define CCO_FCNT_W 16
`define CCO_FILT_RST 6'h1D

// status and event bits
`define CCO_EV_GOPEN 0
`define CCO_EV_GCLOSE 1
`define CCO_EV_CMP 2
`define CCO_EV_OFLW 3
`define CCO_EV_UFLW 4
`define CCO_NUM_EV 5
`define CCO_NUM_IN 4

`endif

// *** hdl/cco_compare_out.v ***
// compare-output and event stage of a 32-bit counter channel
// assumes counter value, step pulses and limit events come from a counter core;
// raw inputs synchronous to clk_sys; registers on a plain one-cycle port
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`include "cco_defs.vh"

// block overview
// the counter core outside this stage owns the count itself; this stage
// only watches the value and the one-cycle update, overflow and underflow
// pulses that come with it.
// the comparator is looked at on update pulses only, so a value that sits
// still never retriggers anything, and a stale compare value written while
// the count rests takes effect with the next update.
// all outputs leave from flip-flops, one cycle after the cause; a user who
// needs the output on the very edge of the count must allow for that cycle.
// events are one-cycle pulses plus a sticky copy for software polling;
// there is no interrupt logic here, the event pulses go to whoever owns it.

module cco_compare_out (
  input wire clk_sys, // system clock, 100 MHz
  input wire srst, // synchronous reset, active high
  input wire [3:0] reg_addr, // register index
  input wire [31:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [31:0] reg_rdata, // read data, cycle after strobe
  input wire [31:0] count_val, // current counter value, signed
  input wire count_upd, // one-cycle counter update pulse
  input wire count_up, // direction of that update, 1 = up
  input wire count_oflw, // one-cycle overflow pulse
  input wire count_uflw, // one-cycle underflow pulse
  input wire sw_gate, // software gate of channel 3
  input wire [3:0] raw_in, // raw track a, track b, hw gate, latch
  output reg [3:0] filt_out, // filtered inputs, same order
  output reg chan_out, // channel digital output
  output reg compare_status_flag, // comparator status
  output reg [4:0] event_out // one-cycle events, enabled ones only
);

  // configuration registers
  reg [31:0] ctrl_reg; // characteristic, direction, enables, dout
  reg [31:0] ctrl_next;
  reg [31:0] cmpval_reg; // signed comparison value
  reg [31:0] cmpval_next;
  reg [7:0] plen_cfg_reg; // pulse length code, 2 ms each
  reg [7:0] plen_cfg_next;
  reg [7:0] hyst_reg; // hysteresis band
  reg [7:0] hyst_next;
  reg [5:0] filt_cfg_reg; // [2:0] count/gate freq, [5:3] latch freq
  reg [5:0] filt_cfg_next;
  reg [4:0] ev_sticky_reg; // sticky record of raised events
  reg [4:0] ev_sticky_next;

  wire [1:0] char_sel = ctrl_reg[`CCO_CTRL_CHAR_HI:`CCO_CTRL_CHAR_LO];
  wire [1:0] dir_sel = ctrl_reg[`CCO_CTRL_DIR_HI:`CCO_CTRL_DIR_LO];

  // minimum width in clock cycles for a frequency code
  // the widths of 80000 ns and above exceed 16 bits, so divide first and cut afterwards;
  // the longest width still fits the 16-bit counter after division
  // codes above the last named one fall back to the fastest setting
  function [`CCO_FCNT_W-1:0] min_cycles;
    input [2:0] sel;
    reg [31:0] ns;
    reg [31:0] cyc;
    begin
      case (sel)
        `CCO_F1K: ns = `CCO_W1K_NS;
        `CCO_F2K: ns = `CCO_W2K_NS;
        `CCO_F5K: ns = `CCO_W5K_NS;
        `CCO_F10K: ns = `CCO_W10K_NS;
        `CCO_F30K: ns = `CCO_W30K_NS;
        default: ns = `CCO_W60K_NS;
      endcase
      cyc = ns / `CCO_CLK_NS;
      min_cycles = cyc[`CCO_FCNT_W-1:0];
    end
  endfunction

  // input pulse filters: a new level must stay stable for the minimum width
  // the filter adds its own width as latency to every accepted edge;
  // a slower frequency setting therefore also delays gate events
  // filter next levels, gathered so that one process owns filt_out
  wire [3:0] filt_nx;

  genvar gi;
  generate
    for (gi = 0; gi < `CCO_NUM_IN; gi = gi + 1) begin : g_filt
      reg [`CCO_FCNT_W-1:0] cnt_reg; // stable-level counter
      wire [2:0] fsel = (gi == 3) ? filt_cfg_reg[5:3] : filt_cfg_reg[2:0];
      wire [`CCO_FCNT_W-1:0] lim = min_cycles(fsel);
      wire differ = raw_in[gi] != filt_out[gi]; // raw level departs from filtered
      wire done = (cnt_reg + 16'h0001) >= lim; // new level held long enough
      assign filt_nx[gi] = (differ && done) ? raw_in[gi] : filt_out[gi];
      // width counter of one line
      always @(posedge clk_sys) begin
        if (srst) begin
          cnt_reg <= 16'h0000;
        end else if (!differ || done) begin
          cnt_reg <= 16'h0000; // glitch ended or level taken: restart
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  endgenerate

  // filtered levels, one register for all four lines
  always @(posedge clk_sys) begin
    if (srst) begin
      filt_out <= 4'h0;
    end else begin
      filt_out <= filt_nx;
    end
  end

  // register writes
  // writes take effect on the next edge; there is no shadowing, so a
  // compare value changed between updates is used by the next update.
  // the pulse length code is not shadowed either: the timer copies it
  // when a pulse starts, which is what keeps a running pulse unchanged.
  // unmapped indices fall into the default branch and change nothing
  always @* begin
    ctrl_next = ctrl_reg;
    cmpval_next = cmpval_reg;
    plen_cfg_next = plen_cfg_reg;
    hyst_next = hyst_reg;
    filt_cfg_next = filt_cfg_reg;
    if (reg_wr) begin
      case (reg_addr)
        `CCO_REG_CTRL: ctrl_next = reg_wdata;
        `CCO_REG_CMPVAL: cmpval_next = reg_wdata;
        `CCO_REG_PULSE: plen_cfg_next = reg_wdata[7:0];
        `CCO_REG_HYST: hyst_next = reg_wdata[7:0];
        `CCO_REG_FILT: filt_cfg_next = reg_wdata[5:0];
        default: ctrl_next = ctrl_reg; // read-only, event clear (handled below) or unmapped
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg <= `CCO_CTRL_RST;
      cmpval_reg <= 32'h0000_0000;
      plen_cfg_reg <= 8'h00;
      hyst_reg <= 8'h00;
      filt_cfg_reg <= `CCO_FILT_RST; // latch 10 kHz, count 60 kHz
    end else begin
      ctrl_reg <= ctrl_next;
      cmpval_reg <= cmpval_next;
      plen_cfg_reg <= plen_cfg_next;
      hyst_reg <= hyst_next;
      filt_cfg_reg <= filt_cfg_next;
    end
  end

  // signed comparisons, extended by one bit to hold the hysteresis band
  // without the extra bit, compare value minus band could wrap at the
  // most negative count and release the output at the wrong place.
  // band settings of 0 and 1 both mean no band, so a release then
  // happens as soon as the plain condition fails
  wire signed [32:0] cnt_s = {count_val[31], count_val};
  wire signed [32:0] cmp_s = {cmpval_reg[31], cmpval_reg};
  wire signed [32:0] hys_s = (hyst_reg > 8'h01) ? {25'h0000000, hyst_reg} : 33'h000000000;
  wire ge_now = cnt_s >= cmp_s;
  wire le_now = cnt_s <= cmp_s;
  wire ge_off = cnt_s < (cmp_s - hys_s); // hysteresis release for ge
  wire le_off = cnt_s > (cmp_s + hys_s); // hysteresis release for le
  wire eq_now = cnt_s == cmp_s;
  wire dir_ok = (dir_sel == `CCO_DIR_UP) ? count_up :
                (dir_sel == `CCO_DIR_DOWN) ? !count_up : 1'b1;

  // comparator state and pulse timing
  // the millisecond timebase is a free cycle counter that restarts with
  // every pulse, so the pulse length error stays within one clock cycle
  // rather than a whole millisecond; trading a 17-bit counter for that.
  // the remaining count is in whole milliseconds, twice the length code
  reg cmp_reg; // comparison condition with hysteresis
  reg cmp_next;
  reg pulse_on_reg; // timed pulse running
  reg pulse_on_next;
  reg [`CCO_PLEN_W-1:0] ms_left_reg; // milliseconds remaining
  reg [`CCO_PLEN_W-1:0] ms_left_next;
  reg [`CCO_MS_W-1:0] tick_reg; // cycles within current millisecond
  reg [`CCO_MS_W-1:0] tick_next;
  reg out_next;
  reg flag_next;
  reg trig;

  // next state of comparator, pulse timer and output
  // trig marks the rising of the condition on an update; only a rise
  // starts a pulse, so sitting on the compare value gives one pulse.
  // leaving the pulse characteristic stops a running pulse at once.
  // a length of zero never starts the timer: the output then simply
  // follows the equality condition qualified by direction, update by update
  always @* begin
    cmp_next = cmp_reg;
    pulse_on_next = pulse_on_reg;
    ms_left_next = ms_left_reg;
    tick_next = tick_reg;
    trig = 1'b0;
    // comparator evaluated on counter updates only
    if (count_upd) begin
      case (char_sel)
        `CCO_CHAR_GE: begin
          if (ge_now) cmp_next = 1'b1;
          else if (ge_off) cmp_next = 1'b0;
        end
        `CCO_CHAR_LE: begin
          if (le_now) cmp_next = 1'b1;
          else if (le_off) cmp_next = 1'b0;
        end
        `CCO_CHAR_PULSE: cmp_next = eq_now && dir_ok;
        default: cmp_next = 1'b0;
      endcase
      trig = cmp_next && !cmp_reg;
    end
    if (char_sel != `CCO_CHAR_PULSE) begin
      pulse_on_next = 1'b0;
    end else if (pulse_on_reg) begin
      // running pulse ignores re-reaching the value
      if (tick_reg == `CCO_MS_CYCLES - 1) begin
        tick_next = {`CCO_MS_W{1'b0}};
        ms_left_next = ms_left_reg - 10'h001;
        if (ms_left_reg == 10'h001) pulse_on_next = 1'b0;
      end else begin
        tick_next = tick_reg + 17'h00001;
      end
    end else if (trig && plen_cfg_reg != 8'h00) begin
      // length latched now, later writes wait for the next pulse
      pulse_on_next = 1'b1;
      tick_next = {`CCO_MS_W{1'b0}};
      // code times the 2 ms step, kept at the timer's width
      ms_left_next = {1'b0, plen_cfg_reg, 1'b0};
    end
    // output characteristic drives pin and flag
    case (char_sel)
      `CCO_CHAR_NONE: begin
        out_next = ctrl_reg[`CCO_CTRL_DOUT];
        flag_next = 1'b0;
      end
      `CCO_CHAR_PULSE: begin
        // zero length holds output while value is met; a running pulse
        // keeps its old length even if the code is cleared meanwhile
        out_next = pulse_on_next || ((plen_cfg_reg == 8'h00) && cmp_next);
        flag_next = out_next;
      end
      default: begin
        out_next = cmp_next;
        flag_next = cmp_next;
      end
    endcase
  end

  // gate edge detect on filtered hardware gate
  // the delayed copy resets low like the filtered gate, so no false edge
  // appears after reset; the software gate only qualifies the event,
  // it does not gate the edge detector itself.
  // events need their enable bit; a disabled source leaves no sticky trace
  reg gate_d_reg; // previous filtered gate level
  wire gate_rise = filt_out[2] && !gate_d_reg;
  wire gate_fall = !filt_out[2] && gate_d_reg;
  reg [4:0] ev_raw;

  always @* begin
    ev_raw = 5'h00;
    ev_raw[`CCO_EV_GOPEN] = gate_rise && sw_gate && ctrl_reg[`CCO_CTRL_IE_GOPEN];
    ev_raw[`CCO_EV_GCLOSE] = gate_fall && sw_gate && ctrl_reg[`CCO_CTRL_IE_GCLOSE];
    ev_raw[`CCO_EV_CMP] = trig && (char_sel != `CCO_CHAR_NONE)
                          && ctrl_reg[`CCO_CTRL_IE_CMP];
    ev_raw[`CCO_EV_OFLW] = count_oflw && ctrl_reg[`CCO_CTRL_IE_OFLW];
    ev_raw[`CCO_EV_UFLW] = count_uflw && ctrl_reg[`CCO_CTRL_IE_UFLW];
    // sticky record: new event wins over a clear in the same cycle
    ev_sticky_next = ev_sticky_reg;
    if (reg_wr && reg_addr == `CCO_REG_EVENT) ev_sticky_next = ev_sticky_reg & ~reg_wdata[4:0];
    ev_sticky_next = ev_sticky_next | ev_raw;
  end

  // state and output flip-flops
  // the channel output, flag and events are registered here so that downstream logic sees clean
  // levels; the cost is one cycle between an update and the output.
  // the sticky record is cleared by reset only and by writing ones
  always @(posedge clk_sys) begin
    if (srst) begin
      cmp_reg <= 1'b0;
      pulse_on_reg <= 1'b0;
      ms_left_reg <= 10'h000;
      tick_reg <= 17'h00000;
      gate_d_reg <= 1'b0;
      ev_sticky_reg <= 5'h00;
      chan_out <= 1'b0;
      compare_status_flag <= 1'b0;
      event_out <= 5'h00;
    end else begin
      cmp_reg <= cmp_next;
      pulse_on_reg <= pulse_on_next;
      ms_left_reg <= ms_left_next;
      tick_reg <= tick_next;
      gate_d_reg <= filt_out[2];
      ev_sticky_reg <= ev_sticky_next;
      chan_out <= out_next;
      compare_status_flag <= flag_next;
      event_out <= ev_raw;
    end
  end

  // read data, valid the cycle after the strobe only
  // read data return to zero outside that cycle, so a master that samples
  // late sees zero rather than stale data; the count read is the value
  // on the port at the strobe, not a frozen copy.
  // the status word drops the output bit: the flag sits in bit zero
  always @(posedge clk_sys) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        `CCO_REG_CTRL: reg_rdata <= ctrl_reg;
        `CCO_REG_CMPVAL: reg_rdata <= cmpval_reg;
        `CCO_REG_PULSE: reg_rdata <= {24'h000000, plen_cfg_reg};
        `CCO_REG_HYST: reg_rdata <= {24'h000000, hyst_reg};
        `CCO_REG_FILT: reg_rdata <= {26'h0000000, filt_cfg_reg};
        `CCO_REG_COUNT: reg_rdata <= count_val;
        `CCO_REG_STATUS: reg_rdata <= {25'h0000000, pulse_on_reg, filt_out,
                                       compare_status_flag, chan_out} >> 1;
        `CCO_REG_EVENT: reg_rdata <= {27'h0000000, ev_sticky_reg};
        default: reg_rdata <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

endmodule

// *** dv/cco_chk.sv ***
// checker: port relations of the compare-output stage
// assumes registers change only through the stage's own register port
module cco_chk (
  input wire clk_sys, // clock
  input wire srst, // reset
  input wire [3:0] reg_addr, // index
  input wire [31:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire [31:0] reg_rdata, // read data
  input wire [31:0] count_val, // count
  input wire count_upd, // update pulse
  input wire count_up, // direction
  input wire count_oflw, // overflow
  input wire count_uflw, // underflow
  input wire chan_out, // output
  input wire compare_status_flag, // flag
  input wire [4:0] event_out // events
);
  reg [31:0] ctl_reg, cmp_reg; // shadow ctrl and compare value
  reg [7:0] hys_reg, pls_reg; // shadow hysteresis and pulse code
  wire [1:0] ch = ctl_reg[1:0]; // characteristic
  wire ge = $signed(count_val) >= $signed(cmp_reg); // at or above
  wire le = $signed(count_val) <= $signed(cmp_reg); // at or below
  // shadows lag writes by one cycle, as the stage does
  always @(posedge clk_sys) begin
    if (srst) begin
      ctl_reg <= 32'h0;
      cmp_reg <= 32'h0;
      hys_reg <= 8'h0;
      pls_reg <= 8'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        4'h0: ctl_reg <= reg_wdata;
        4'h1: cmp_reg <= reg_wdata;
        4'h2: pls_reg <= reg_wdata[7:0];
        4'h3: hys_reg <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  AST_RST: assert property (disable iff (1'b0) srst |=> !chan_out
    && !compare_status_flag && event_out == 5'h0) else $error("outputs set after reset");
  AST_NONE: assert property (count_upd && ch == 2'h0 |=> !compare_status_flag
    && chan_out == $past(ctl_reg[4])) else $error("plain output wrong");
  AST_GE: assert property (count_upd && ch == 2'h1 && ge
    |=> compare_status_flag && chan_out) else $error("ge not set");
  AST_LE: assert property (count_upd && ch == 2'h2 && le
    |=> compare_status_flag && chan_out) else $error("le not set");
  AST_GE_OFF: assert property (count_upd && ch == 2'h1 && !ge && hys_reg < 8'h2
    |=> !compare_status_flag && !chan_out) else $error("ge not cleared");
  AST_PLS0: assert property (count_upd && ch == 2'h3 && pls_reg == 8'h0
    && ctl_reg[3:2] == 2'h0 && count_val == cmp_reg |=> chan_out) else $error("no pulse");
  AST_DIR: assert property (count_upd && ch == 2'h3 && ctl_reg[3:2] == 2'h1
    && !count_up && !chan_out |=> !chan_out) else $error("pulse against direction");
  AST_CMPEV: assert property ($rose(compare_status_flag) && ctl_reg[10]
    && ch != 2'h0 && ch != 2'h3 |-> ##[0:1] event_out[2]) else $error("no compare event");
  AST_OFLW: assert property (count_oflw && ctl_reg[11]
    |-> ##1 event_out[3]) else $error("no overflow event");
  AST_UFLW: assert property (count_uflw && ctl_reg[12]
    |-> ##1 event_out[4]) else $error("no underflow event");
endmodule
bind cco_compare_out cco_chk u_chk (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .count_val(count_val),
  .count_upd(count_upd), .count_up(count_up), .count_oflw(count_oflw),
  .count_uflw(count_uflw), .chan_out(chan_out),
  .compare_status_flag(compare_status_flag), .event_out(event_out));

// *** dv/cco_src.sv ***
// partner: pulse source on the raw track, gate and latch lines
// assumes the bench asks for one pulse at a time; lines idle low
module cco_src (
  input wire logic clk_sys, // clock
  input wire logic go, // start a pulse
  input wire logic [1:0] sel, // raw line to pulse
  input wire logic [15:0] len, // width in cycles
  output logic [3:0] raw_in // raw lines
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left = 16'h0; // cycles still high
  logic [1:0] line = 2'h0; // line in use
  // width is chosen by the bench; short ones probe the rejection
  always @(posedge clk_sys) begin
    if (go) begin
      left <= len;
      line <= sel;
    end else if (left != 16'h0)
      left <= left - 16'h1;
  end
  assign raw_in = (left != 16'h0) ? (4'h1 << line) : 4'h0;
endmodule

// *** dv/cco_compare_out_bench.sv ***
// bench: register and counter-update sequences on the compare stage
// assumes a 100 MHz clock and the pulse source beside the stage
module cco_compare_out_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, srst = 1'b1; // clock, reset held at start
  logic [3:0] reg_addr = 4'h0; // index
  logic [31:0] reg_wdata = 32'h0, count_val = 32'h0; // write data, count
  logic reg_wr = 1'b0, reg_rd = 1'b0, count_upd = 1'b0, count_up = 1'b0; // strobes
  logic count_oflw = 1'b0, count_uflw = 1'b0, sw_gate = 1'b0, go = 1'b0; // events, gate
  logic [1:0] sel = 2'h0; // source line
  logic [15:0] len = 16'h0; // source width
  wire [3:0] raw_in, filt_out; // raw and filtered lines
  wire [31:0] reg_rdata; // read data
  wire chan_out, compare_status_flag; // output and flag
  wire [4:0] event_out; // events
  int mismatches = 0, samples_checked = 0; // counts
  cco_compare_out u_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_val(count_val), .count_upd(count_upd), .count_up(count_up),
    .count_oflw(count_oflw), .count_uflw(count_uflw), .sw_gate(sw_gate), .raw_in(raw_in),
    .filt_out(filt_out), .chan_out(chan_out), .compare_status_flag(compare_status_flag),
    .event_out(event_out));
  cco_src u_src (.clk_sys(clk_sys), .go(go), .sel(sel), .len(len), .raw_in(raw_in));
  initial forever #5 clk_sys = ~clk_sys;
  task conclude;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task r(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // one counter update, then output and flag against {out, flag}
  task u(input logic [31:0] v, input logic up, input logic [1:0] e);
    @(posedge clk_sys);
    count_val <= v;
    count_up <= up;
    count_upd <= 1'b1;
    @(posedge clk_sys);
    count_upd <= 1'b0;
    #1 chk({30'h0, chan_out, compare_status_flag}, {30'h0, e});
  endtask
  task ev;
    @(posedge clk_sys);
    count_oflw <= 1'b1;
    count_uflw <= 1'b1;
    @(posedge clk_sys);
    count_oflw <= 1'b0;
    count_uflw <= 1'b0;
  endtask
  // filter widths fix the waits: 670 cycles at 60 kHz, 4000 at 10 kHz
  task fire(input logic [1:0] s, input logic [15:0] n, input int hold);
    @(posedge clk_sys);
    go <= 1'b1;
    sel <= s;
    len <= n;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (hold) @(posedge clk_sys);
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    r(4'h0, 32'h0);
    r(4'h2, 32'h0);
    r(4'h4, 32'h1D);
    r(4'h7, 32'h0);
    w(4'h9, 32'hFFFF_FFFF);
    r(4'h9, 32'h0);
    w(4'h0, 32'h10);
    u(32'h5, 1'b1, 2'b10);
    w(4'h1, 32'hFFFF_FFFD);
    w(4'h0, 32'h401);
    u(32'hFFFF_FFFC, 1'b1, 2'b00);
    u(32'hFFFF_FFFD, 1'b1, 2'b11);
    u(32'h7FFF_FFFF, 1'b1, 2'b11);
    u(32'h8000_0000, 1'b0, 2'b00);
    r(4'h7, 32'h4);
    w(4'h7, 32'h1F);
    w(4'h0, 32'h2);
    u(32'hFFFF_FFFD, 1'b0, 2'b11);
    u(32'hFFFF_FFFE, 1'b1, 2'b00);
    w(4'h0, 32'h1);
    w(4'h3, 32'h4);
    u(32'hFFFF_FFFD, 1'b1, 2'b11);
    u(32'hFFFF_FFFB, 1'b0, 2'b11);
    u(32'hFFFF_FFF8, 1'b0, 2'b00);
    w(4'h3, 32'h1);
    u(32'hFFFF_FFFD, 1'b1, 2'b11);
    u(32'hFFFF_FFFC, 1'b0, 2'b00);
    w(4'h3, 32'h0);
    w(4'h0, 32'h3);
    u(32'hFFFF_FFFC, 1'b1, 2'b00);
    u(32'hFFFF_FFFD, 1'b1, 2'b11);
    u(32'hFFFF_FFFE, 1'b1, 2'b00);
    w(4'h0, 32'h7);
    u(32'hFFFF_FFFD, 1'b0, 2'b00);
    u(32'hFFFF_FFFC, 1'b1, 2'b00);
    u(32'hFFFF_FFFD, 1'b1, 2'b11);
    w(4'h0, 32'h1800);
    ev;
    r(4'h7, 32'h18);
    w(4'h7, 32'h1F);
    w(4'h0, 32'h0);
    ev;
    r(4'h7, 32'h0);
    w(4'h0, 32'h300);
    sw_gate <= 1'b1;
    fire(2'h2, 16'd300, 1000);
    chk({28'h0, filt_out}, 32'h0);
    r(4'h7, 32'h0);
    fire(2'h2, 16'd1000, 800);
    chk({28'h0, filt_out}, 32'h4);
    repeat (1000) @(posedge clk_sys);
    r(4'h7, 32'h3);
    w(4'h7, 32'h1F);
    sw_gate <= 1'b0;
    fire(2'h2, 16'd1000, 1800);
    r(4'h7, 32'h0);
    fire(2'h3, 16'd2000, 1500);
    chk({28'h0, filt_out}, 32'h0);
    fire(2'h3, 16'd4500, 4300);
    chk({28'h0, filt_out}, 32'h8);
    w(4'h2, 32'h1);
    w(4'h1, 32'hA);
    w(4'h0, 32'h3);
    u(32'h9, 1'b1, 2'b00);
    u(32'hA, 1'b1, 2'b11);
    u(32'hB, 1'b1, 2'b11);
    u(32'hA, 1'b1, 2'b11);
    w(4'h2, 32'h0);
    u(32'hC, 1'b1, 2'b11);
    r(4'h6, 32'h31);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    #1 chk({30'h0, chan_out, compare_status_flag}, 32'h0);
    w(4'h2, 32'hFF);
    r(4'h2, 32'hFF);
    conclude;
  end
endmodule
